// File: dv/tb_branch_trap_sequencer.sv
// self-checking bench for the branch and trap sequencer
`timescale 1ns/1ps
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb_branch_trap_sequencer;
  import bts_pkg::*;
  localparam int NWIN = 8;
  localparam int CW = $clog2(NWIN);
  localparam logic [31:0] DEXT = 32'hFFFF_FFC0;
  localparam logic [19:0] BASE = 20'hABCDE;
  // passing value sets, bit k for condition value k; float and coprocessor tables match
  localparam logic [3:0] VSET [16] = '{4'h0, 4'hE, 4'h6, 4'hA, 4'h2, 4'hC, 4'h4, 4'h8,
    4'hF, 4'h1, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB, 4'h7};
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic instr_valid = 1'h0;
  bts_op_t instr_op = OP_OTHER;
  logic [3:0] cond_field = 4'h0;
  logic annul_bit = 1'h0;
  logic imm_select = 1'h0;
  logic [4:0] dest_index = 5'h0E;
  logic [31:0] source_reg_one = 32'h0;
  logic [31:0] source_reg_two = 32'h0;
  logic [12:0] signed_short_immediate = 13'h0;
  logic [21:0] branch_displacement = 22'h3FFFC0;
  logic [29:0] call_displacement = 30'h100;
  logic [3:0] int_cond_codes = 4'h0;
  logic [1:0] float_cond_code = 2'h0;
  logic [1:0] coproc_cond_code = 2'h0;
  logic [NWIN-1:0] window_invalid_mask = '0;
  logic trap_base_wr_en = 1'h0;
  logic [19:0] trap_base_wr_data = 20'h0;
  logic [31:0] pc_reg, next_program_counter_reg, trap_base_reg;
  logic [31:0] link_wr_data_reg, trap_nxt_wr_data_reg;
  logic annul_reg, trap_enable_bit_reg, supervisor_reg, previous_supervisor_bit_reg;
  logic error_mode_reg, link_wr_en_reg, trap_nxt_wr_en_reg, software_trap_reg;
  logic illegal_instr_trap_reg, reset_trap_reg, window_overflow_reg, window_underflow_reg;
  logic [CW-1:0] current_window_pointer_reg, link_wr_window_reg;
  logic [4:0] link_wr_index_reg;
  int err_count = 0;
  int n_checks = 0;
  // reference state, advanced by the bench on its own
  logic [31:0] m_pc, m_nx;
  logic [CW-1:0] m_wp;
  logic [7:0] m_type;
  logic m_en, m_sup, m_prev;

  always #2 clk = ~clk;

  bts_sequencer #(.NWIN(NWIN)) u_bts_sequencer (
    .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .cond_field(cond_field), .annul_bit(annul_bit), .imm_select(imm_select),
    .dest_index(dest_index), .source_reg_one(source_reg_one),
    .source_reg_two(source_reg_two), .signed_short_immediate(signed_short_immediate),
    .branch_displacement(branch_displacement), .call_displacement(call_displacement),
    .int_cond_codes(int_cond_codes), .float_cond_code(float_cond_code),
    .coproc_cond_code(coproc_cond_code), .window_invalid_mask(window_invalid_mask),
    .trap_base_wr_en(trap_base_wr_en), .trap_base_wr_data(trap_base_wr_data),
    .pc_reg(pc_reg), .next_program_counter_reg(next_program_counter_reg),
    .annul_reg(annul_reg), .trap_base_reg(trap_base_reg),
    .trap_enable_bit_reg(trap_enable_bit_reg), .supervisor_reg(supervisor_reg),
    .previous_supervisor_bit_reg(previous_supervisor_bit_reg),
    .current_window_pointer_reg(current_window_pointer_reg), .error_mode_reg(error_mode_reg),
    .link_wr_en_reg(link_wr_en_reg), .link_wr_window_reg(link_wr_window_reg),
    .link_wr_index_reg(link_wr_index_reg), .link_wr_data_reg(link_wr_data_reg),
    .trap_nxt_wr_en_reg(trap_nxt_wr_en_reg), .trap_nxt_wr_data_reg(trap_nxt_wr_data_reg),
    .software_trap_reg(software_trap_reg), .illegal_instr_trap_reg(illegal_instr_trap_reg),
    .reset_trap_reg(reset_trap_reg), .window_overflow_reg(window_overflow_reg),
    .window_underflow_reg(window_underflow_reg)
  );

  // flags are {n, z, v, c}; upper half of the codes is the complement
  function automatic logic int_true(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'h0;
      3'h1: r = f[2];
      3'h2: r = f[2] | (f[3] ^ f[1]);
      3'h3: r = f[3] ^ f[1];
      3'h4: r = f[0] | f[2];
      3'h5: r = f[0];
      3'h6: r = f[3];
      default: r = f[1];
    endcase
    return r ^ c[3];
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // presents one instruction at this edge; keep leaves valid up for a back-to-back one
  task automatic put(input bts_op_t op, input logic [3:0] c, input logic a, input logic keep);
    instr_valid <= 1'h1;
    instr_op <= op;
    cond_field <= c;
    annul_bit <= a;
    @(posedge clk);
    if (!keep) instr_valid <= 1'h0;
  endtask

  task automatic step(input logic take, input logic [31:0] tgt);
    m_pc = m_nx;
    m_nx = take ? tgt : m_nx + 32'h4;
  endtask

  task automatic pc_chk();
    `CK(pc_reg, m_pc)
    `CK(next_program_counter_reg, m_nx)
  endtask

  task automatic do_reset();
    reset <= 1'h1;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    m_pc = 32'h0;
    m_nx = 32'h4;
    m_wp = '0;
    m_type = 8'h00;
    m_en = 1'h0;
    m_sup = 1'h1;
    m_prev = 1'h0;
    @(negedge clk);
    pc_chk();
    `CK(supervisor_reg, 1'h1)
    @(posedge clk);
  endtask

  task automatic branch(input bts_op_t op, input logic [3:0] c, input logic take);
    logic [31:0] tgt;
    tgt = m_pc + 32'h4 + DEXT;
    put(op, c, 1'h0, 1'h0);
    step(take, tgt);
    @(negedge clk);
    pc_chk();
    @(posedge clk);
  endtask

  // branch, then a slot that is a save or a trap; an annulled slot must leave no trace
  task automatic annul_case(input bts_op_t op, input logic [3:0] c, input logic a,
      input logic take, input logic ann, input bts_op_t slot);
    step(take, m_pc + 32'h4 + DEXT);
    put(op, c, a, 1'h0);
    @(negedge clk);
    `CK(annul_reg, ann)
    @(posedge clk);
    put(slot, 4'h8, 1'h0, 1'h0);
    step(1'h0, 32'h0);
    if (!ann) m_wp = m_wp - 1'h1;
    @(negedge clk);
    pc_chk();
    `CK(current_window_pointer_reg, m_wp)
    `CK(software_trap_reg, 1'h0)
    @(posedge clk);
  endtask

  task automatic win_step(input bts_op_t op, input logic [NWIN-1:0] mask, input logic flag);
    logic [CW-1:0] nw;
    nw = (op == OP_SAVE) ? m_wp - 1'h1 : m_wp + 1'h1;
    window_invalid_mask <= mask;
    source_reg_one <= 32'h100;
    source_reg_two <= 32'h24;
    imm_select <= 1'h0;
    put(op, 4'h0, 1'h0, 1'h0);
    step(1'h0, 32'h0);
    if (!flag) m_wp = nw;
    @(negedge clk);
    pc_chk();
    `CK(current_window_pointer_reg, m_wp)
    `CK(window_overflow_reg, flag && op == OP_SAVE)
    `CK(window_underflow_reg, flag && op == OP_RESTORE)
    `CK(link_wr_en_reg, !flag)
    if (!flag) `CK(link_wr_data_reg, 32'h124)
    @(posedge clk);
    window_invalid_mask <= '0;
  endtask

  task automatic trap_case(input logic [3:0] c, input logic ix, input logic [31:0] a,
      input logic [31:0] b, input logic [12:0] imm);
    logic [31:0] opc, onx, sum;
    logic take;
    opc = m_pc;
    onx = m_nx;
    sum = a + (ix ? {{19{imm[12]}}, imm} : b);
    take = int_true(c, int_cond_codes);
    imm_select <= ix;
    source_reg_one <= a;
    source_reg_two <= b;
    signed_short_immediate <= imm;
    put(OP_COND_TRAP, c, 1'h0, 1'h0);
    if (take) begin
      m_type = 8'h80 + {1'h0, sum[6:0]};
      m_wp = m_wp - 1'h1;
      m_prev = m_sup;
      m_sup = 1'h1;
      m_en = 1'h0;
      m_pc = {BASE, 12'h000};
      m_nx = m_pc + 32'h4;
    end else begin
      step(1'h0, 32'h0);
    end
    @(negedge clk);
    pc_chk();
    `CK(software_trap_reg, take)
    `CK(trap_base_reg, {BASE, m_type, 4'h0})
    `CK(trap_enable_bit_reg, m_en)
    `CK(previous_supervisor_bit_reg, m_prev)
    `CK(current_window_pointer_reg, m_wp)
    `CK(trap_nxt_wr_en_reg, take)
    if (take) begin
      `CK(link_wr_index_reg, 5'h11)
      `CK(link_wr_window_reg, m_wp)
      `CK(link_wr_data_reg, opc)
      `CK(trap_nxt_wr_data_reg, onx)
    end
    @(posedge clk);
  endtask

  // kind 0 clean, 1 illegal with traps on, 2 fatal; a faulting return holds the pc pair
  task automatic ret_case(input logic [31:0] tgt, input logic [NWIN-1:0] mask,
      input logic [1:0] kind);
    source_reg_one <= tgt;
    source_reg_two <= 32'h0;
    imm_select <= 1'h0;
    window_invalid_mask <= mask;
    put(OP_RETURN_TRAP, 4'h0, 1'h0, 1'h0);
    if (kind == 2'h0) begin
      m_wp = m_wp + 1'h1;
      m_en = 1'h1;
      m_sup = m_prev;
      step(1'h1, tgt);
    end
    @(negedge clk);
    pc_chk();
    `CK(illegal_instr_trap_reg, kind == 2'h1)
    `CK(reset_trap_reg, kind == 2'h2)
    `CK(error_mode_reg, kind == 2'h2)
    `CK(trap_enable_bit_reg, m_en)
    `CK(supervisor_reg, m_sup)
    if (kind == 2'h0) `CK(current_window_pointer_reg, m_wp)
    @(posedge clk);
    window_invalid_mask <= '0;
  endtask

  task automatic call_jump();
    logic [31:0] p0;
    p0 = m_pc;
    put(OP_CALL, 4'h0, 1'h0, 1'h0);
    step(1'h1, p0 + 32'h400);
    @(negedge clk);
    pc_chk();
    `CK(link_wr_index_reg, 5'h0F)
    `CK(link_wr_data_reg, p0)
    @(posedge clk);
    p0 = m_pc;
    imm_select <= 1'h1;
    source_reg_one <= 32'h1000;
    signed_short_immediate <= 13'h1FF8;
    dest_index <= 5'h07;
    put(OP_JUMP_LINK, 4'h0, 1'h0, 1'h0);
    step(1'h1, 32'h0FF8);
    @(negedge clk);
    pc_chk();
    `CK(link_wr_index_reg, 5'h07)
    `CK(link_wr_data_reg, p0)
    @(posedge clk);
    // couple: call, branch always in its slot, then the call target as the branch slot
    put(OP_CALL, 4'h0, 1'h0, 1'h1);
    step(1'h1, m_pc + 32'h400);
    put(OP_INT_BRANCH, 4'h8, 1'h0, 1'h1);
    step(1'h1, m_pc + 32'h4 + DEXT);
    put(OP_OTHER, 4'h0, 1'h0, 1'h0);
    step(1'h0, 32'h0);
    @(negedge clk);
    pc_chk();
    @(posedge clk);
  endtask

  // hang guard, sized well above the fewer than nine hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    do_reset();
    for (int f = 0; f < 16; f++) begin
      int_cond_codes <= f[3:0];
      for (int c = 0; c < 16; c++) branch(OP_INT_BRANCH, c[3:0], int_true(c[3:0], f[3:0]));
    end
    for (int v = 0; v < 4; v++) begin
      float_cond_code <= v[1:0];
      coproc_cond_code <= 2'h3 - v[1:0];
      for (int c = 0; c < 16; c++) begin
        branch(OP_FLOAT_BRANCH, c[3:0], VSET[c][v]);
        branch(OP_COPROC_BRANCH, c[3:0], VSET[c][3 - v]);
      end
    end
    $display("done conditions");
    int_cond_codes <= 4'h4;
    annul_case(OP_INT_BRANCH, 4'h8, 1'h1, 1'h1, 1'h1, OP_COND_TRAP);
    annul_case(OP_FLOAT_BRANCH, 4'h8, 1'h1, 1'h1, 1'h1, OP_SAVE);
    annul_case(OP_INT_BRANCH, 4'h1, 1'h1, 1'h1, 1'h0, OP_SAVE);
    annul_case(OP_INT_BRANCH, 4'h9, 1'h1, 1'h0, 1'h1, OP_SAVE);
    annul_case(OP_INT_BRANCH, 4'h9, 1'h0, 1'h0, 1'h0, OP_SAVE);
    annul_case(OP_COPROC_BRANCH, 4'h0, 1'h1, 1'h0, 1'h1, OP_COND_TRAP);
    $display("done annul");
    do_reset();
    win_step(OP_SAVE, 8'h00, 1'h0);
    win_step(OP_RESTORE, 8'h00, 1'h0);
    win_step(OP_RESTORE, 8'h00, 1'h0);
    win_step(OP_SAVE, 8'h01, 1'h1);
    win_step(OP_RESTORE, 8'h04, 1'h1);
    $display("done windows");
    int_cond_codes <= 4'h0;
    trap_base_wr_data <= BASE;
    trap_base_wr_en <= 1'h1;
    @(posedge clk);
    trap_base_wr_en <= 1'h0;
    trap_case(4'h1, 1'h0, 32'h5, 32'h7, 13'h0000);
    trap_case(4'h9, 1'h0, 32'hF0, 32'h15, 13'h0000);
    trap_case(4'h8, 1'h1, 32'h3, 32'h0, 13'h1F7C);
    ret_case(32'h2040, '0, 2'h0);
    ret_case(32'h2080, '0, 2'h1);
    trap_case(4'h8, 1'h0, 32'h1, 32'h1, 13'h0000);
    ret_case(32'h2040, 8'h01 << (m_wp + 1'h1), 2'h2);
    // error mode refuses every instruction until reset; trap base writes still land
    put(OP_CALL, 4'h0, 1'h0, 1'h0);
    @(negedge clk);
    pc_chk();
    `CK(link_wr_en_reg, 1'h0)
    @(posedge clk);
    do_reset();
    ret_case(32'h2042, '0, 2'h2);
    $display("done traps");
    do_reset();
    call_jump();
    $display("done calls");
    conclude();
  end
endmodule

// File: inc/bts_map.svh
// constants: reset values, field positions and fixed register indices of the sequencer
`ifndef BTS_MAP_SVH
`define BTS_MAP_SVH
`define BTS_PC_RESET 32'h0000_0000
`define BTS_NXT_RESET 32'h0000_0004
`define BTS_PC_STEP 32'h0000_0004
`define BTS_TRAP_BASE_RESET 32'h0000_0000
`define BTS_SW_TRAP_OFFSET 8'h80
`define BTS_TY_LSB 4
`define BTS_TY_MSB 11
`define BTS_TBA_LSB 12
`define BTS_TRAP_NUM_MSB 6
`define BTS_CALL_LINK_INDEX 5'h0F
`define BTS_TRAP_PC_INDEX 5'h11
`define BTS_TRAP_NXT_INDEX 5'h12
`define BTS_COND_NEVER 4'h0
`define BTS_COND_ALWAYS 4'h8
`define BTS_SUPERVISOR_RESET 1'h1
`define BTS_TRAP_ENABLE_RESET 1'h0
`endif

// File: inc/bts_pkg.sv
// types shared by the branch and trap sequencer
package bts_pkg;
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_INT_BRANCH,
    OP_FLOAT_BRANCH,
    OP_COPROC_BRANCH,
    OP_COND_TRAP,
    OP_CALL,
    OP_JUMP_LINK,
    OP_RETURN_TRAP,
    OP_SAVE,
    OP_RESTORE
  } bts_op_t;
endpackage

// File: src/bts_cond_eval.sv
// condition evaluator for integer, floating-point and coprocessor condition fields
`timescale 1ns/1ps
module bts_cond_eval (
  input wire logic [3:0] cond_field,
  input wire logic [3:0] int_cond_codes,
  input wire logic [1:0] float_cond_code,
  input wire logic [1:0] coproc_cond_code,
  output logic int_true,
  output logic float_true,
  output logic coproc_true
);
  // integer test; codes are n,z,v,c from msb down, upper half is the complement
  function automatic logic int_test(input logic [3:0] c, input logic [3:0] cc);
    logic n, z, v, cy, r;
    n = cc[3];
    z = cc[2];
    v = cc[1];
    cy = cc[0];
    unique case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = z;
      3'h2: r = z | (n ^ v);
      3'h3: r = n ^ v;
      3'h4: r = cy | z;
      3'h5: r = cy;
      3'h6: r = n;
      3'h7: r = v;
    endcase
    return c[3] ? ~r : r;
  endfunction

  // set of two-bit condition values that pass; float and coprocessor tables share it
  function automatic logic [3:0] value_set(input logic [3:0] c);
    logic [3:0] m;
    unique case (c[2:0])
      3'h0: m = 4'h0;
      3'h1: m = 4'hE;
      3'h2: m = 4'h6;
      3'h3: m = 4'hA;
      3'h4: m = 4'h2;
      3'h5: m = 4'hC;
      3'h6: m = 4'h4;
      3'h7: m = 4'h8;
    endcase
    return c[3] ? ~m : m;
  endfunction

  // a call result cannot be indexed, so the set is held in a net first
  logic [3:0] pass_set;
  assign pass_set = value_set(cond_field);

  // float value 0 equal, 1 less, 2 greater, 3 unordered
  always_comb begin
    int_true = int_test(cond_field, int_cond_codes);
    float_true = pass_set[float_cond_code];
    coproc_true = pass_set[coproc_cond_code];
  end
endmodule

// File: src/bts_sequencer.sv
// branch, trap, call and window sequencer that owns the program counter pair
// Overview of operation
// - true conditional trap enters at once, else no-op
// - trap type field gets trap number plus 128
// - trap number is low seven bits of sum
// - trap entry updates state, links locals, jumps base
// - integer conditions never..overflow, upper half complements
// - floating conditions decoded per sixteen-entry table
// - coprocessor conditions test value against fixed sets
// - return steps window up; illegal if traps enabled
// - return faults enter error mode on listed conditions
// - clean return enables traps, restores supervisor, sets next
// - call target pc-relative word; link into r15
// - jump target register sum; link into destination
// - save decrements window and performs add
// - restore increments window and performs add
// - save and restore check mask, flag over/underflow
// - pc takes next; next advances four or target
// - delayed transfer executes following instruction first
// - delay instruction is the one at next
// - untaken branch annuls delay slot when annul set
// - always-form with annul annuls; taken ignores annul
// - annulled instruction changes nothing and never traps
// - branch target is pc plus four plus displacement
`timescale 1ns/1ps
`include "bts_map.svh"
module bts_sequencer #(
  parameter int NWIN = 8,
  parameter int CW = $clog2(NWIN)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire bts_pkg::bts_op_t instr_op,
  input wire logic [3:0] cond_field,
  input wire logic annul_bit,
  input wire logic imm_select,
  input wire logic [4:0] dest_index,
  input wire logic [31:0] source_reg_one,
  input wire logic [31:0] source_reg_two,
  input wire logic [12:0] signed_short_immediate,
  input wire logic [21:0] branch_displacement,
  input wire logic [29:0] call_displacement,
  input wire logic [3:0] int_cond_codes,
  input wire logic [1:0] float_cond_code,
  input wire logic [1:0] coproc_cond_code,
  input wire logic [NWIN-1:0] window_invalid_mask,
  input wire logic trap_base_wr_en,
  input wire logic [19:0] trap_base_wr_data,
  output logic [31:0] pc_reg,
  output logic [31:0] next_program_counter_reg,
  output logic annul_reg,
  output logic [31:0] trap_base_reg,
  output logic trap_enable_bit_reg,
  output logic supervisor_reg,
  output logic previous_supervisor_bit_reg,
  output logic [CW-1:0] current_window_pointer_reg,
  output logic error_mode_reg,
  output logic link_wr_en_reg,
  output logic [CW-1:0] link_wr_window_reg,
  output logic [4:0] link_wr_index_reg,
  output logic [31:0] link_wr_data_reg,
  output logic trap_nxt_wr_en_reg,
  output logic [31:0] trap_nxt_wr_data_reg,
  output logic software_trap_reg,
  output logic illegal_instr_trap_reg,
  output logic reset_trap_reg,
  output logic window_overflow_reg,
  output logic window_underflow_reg
);
  import bts_pkg::*;

  logic int_true, float_true, coproc_true;
  logic [CW-1:0] wp_inc, wp_dec;
  logic inc_invalid, dec_invalid;

  bts_cond_eval u_bts_cond_eval (
    .cond_field(cond_field),
    .int_cond_codes(int_cond_codes),
    .float_cond_code(float_cond_code),
    .coproc_cond_code(coproc_cond_code),
    .int_true(int_true),
    .float_true(float_true),
    .coproc_true(coproc_true)
  );

  bts_window_unit #(.NWIN(NWIN), .CW(CW)) u_bts_window_unit (
    .wp(current_window_pointer_reg),
    .invalid_mask(window_invalid_mask),
    .wp_inc(wp_inc),
    .wp_dec(wp_dec),
    .inc_invalid(inc_invalid),
    .dec_invalid(dec_invalid)
  );

  // instruction acceptance; an annulled slot only steps the counter pair
  logic go, exec;
  assign go = instr_valid & ~error_mode_reg;
  assign exec = go & ~annul_reg;

  // operand sum shared by trap number, jump target, return target and window add
  logic [31:0] reg_sum, trap_base_addr, branch_target, call_target;
  assign reg_sum = source_reg_one + (imm_select ?
    {{19{signed_short_immediate[12]}}, signed_short_immediate} : source_reg_two);
  assign trap_base_addr = {trap_base_reg[31:`BTS_TBA_LSB], `BTS_TBA_LSB'(0)};
  assign branch_target = pc_reg + `BTS_PC_STEP +
    {{10{branch_displacement[21]}}, branch_displacement};
  assign call_target = pc_reg + {call_displacement, 2'h0};

  // branch evaluation across the three condition sources
  logic is_branch, branch_true, always_form;
  always_comb begin
    is_branch = 1'b0;
    branch_true = 1'b0;
    unique case (instr_op)
      OP_INT_BRANCH: begin
        is_branch = 1'b1;
        branch_true = int_true;
      end
      OP_FLOAT_BRANCH: begin
        is_branch = 1'b1;
        branch_true = float_true;
      end
      OP_COPROC_BRANCH: begin
        is_branch = 1'b1;
        branch_true = coproc_true;
      end
      default: begin
        is_branch = 1'b0;
        branch_true = 1'b0;
      end
    endcase
  end
  assign always_form = (cond_field == `BTS_COND_ALWAYS);

  // outcome terms of each executed transfer
  logic trap_taken, ret_exec, ret_illegal, ret_fault, ret_ok;
  logic save_ok, save_ovf, restore_ok, restore_unf;
  assign trap_taken = exec & (instr_op == OP_COND_TRAP) & int_true;
  assign ret_exec = exec & (instr_op == OP_RETURN_TRAP);
  assign ret_illegal = ret_exec & trap_enable_bit_reg;
  assign ret_fault = ret_exec & ~trap_enable_bit_reg &
    (~supervisor_reg | inc_invalid | (reg_sum[1:0] != 2'h0));
  assign ret_ok = ret_exec & ~ret_illegal & ~ret_fault;
  assign save_ok = exec & (instr_op == OP_SAVE) & ~dec_invalid;
  assign save_ovf = exec & (instr_op == OP_SAVE) & dec_invalid;
  assign restore_ok = exec & (instr_op == OP_RESTORE) & ~inc_invalid;
  assign restore_unf = exec & (instr_op == OP_RESTORE) & inc_invalid;

  // next values of the counter pair
  logic [31:0] pc_next, next_program_counter_next;
  always_comb begin
    pc_next = pc_reg;
    next_program_counter_next = next_program_counter_reg;
    if (go) begin
      pc_next = next_program_counter_reg;
      next_program_counter_next = next_program_counter_reg + `BTS_PC_STEP;
    end
    if (trap_taken) begin
      pc_next = trap_base_addr;
      next_program_counter_next = trap_base_addr + `BTS_PC_STEP;
    end else if (exec) begin
      // only the next counter moves, so the slot at the old next runs first
      if (is_branch && branch_true) begin
        next_program_counter_next = branch_target;
      end else if (instr_op == OP_CALL) begin
        next_program_counter_next = call_target;
      end else if (instr_op == OP_JUMP_LINK) begin
        next_program_counter_next = reg_sum;
      end else if (ret_ok) begin
        next_program_counter_next = reg_sum;
      end
    end
    // illegal and fatal returns hand control to trap logic, pair is held
    if (ret_illegal || ret_fault) begin
      pc_next = pc_reg;
      next_program_counter_next = next_program_counter_reg;
    end
  end

  // program counter pair
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_reg <= `BTS_PC_RESET;
      next_program_counter_reg <= `BTS_NXT_RESET;
    end else begin
      pc_reg <= pc_next;
      next_program_counter_reg <= next_program_counter_next;
    end
  end

  // annul flag for the coming delay slot; taken conditional ignores the bit
  always_ff @(posedge clk) begin
    if (reset) begin
      annul_reg <= 1'b0;
    end else if (go) begin
      annul_reg <= exec & is_branch & annul_bit & (~branch_true | always_form);
    end
  end

  // processor state bits and window pointer
  always_ff @(posedge clk) begin
    if (reset) begin
      trap_enable_bit_reg <= `BTS_TRAP_ENABLE_RESET;
      supervisor_reg <= `BTS_SUPERVISOR_RESET;
      previous_supervisor_bit_reg <= 1'b0;
      current_window_pointer_reg <= '0;
    end else if (trap_taken) begin
      trap_enable_bit_reg <= 1'b0;
      previous_supervisor_bit_reg <= supervisor_reg;
      supervisor_reg <= 1'b1;
      current_window_pointer_reg <= wp_dec;
    end else if (ret_ok) begin
      trap_enable_bit_reg <= 1'b1;
      supervisor_reg <= previous_supervisor_bit_reg;
      current_window_pointer_reg <= wp_inc;
    end else if (save_ok) begin
      current_window_pointer_reg <= wp_dec;
    end else if (restore_ok) begin
      current_window_pointer_reg <= wp_inc;
    end
  end

  // error mode is sticky until reset
  always_ff @(posedge clk) begin
    if (reset) begin
      error_mode_reg <= 1'b0;
    end else if (ret_fault) begin
      error_mode_reg <= 1'b1;
    end
  end

  // trap base register; a taken trap and a software write of the base in one cycle both land, on separate fields
  always_ff @(posedge clk) begin
    if (reset) begin
      trap_base_reg <= `BTS_TRAP_BASE_RESET;
    end else begin
      if (trap_base_wr_en) begin
        trap_base_reg[31:`BTS_TBA_LSB] <= trap_base_wr_data;
      end
      if (trap_taken) begin
        trap_base_reg[`BTS_TY_MSB:`BTS_TY_LSB] <= `BTS_SW_TRAP_OFFSET +
          {1'b0, reg_sum[`BTS_TRAP_NUM_MSB:0]};
      end
    end
  end

  // register file write-backs for links, trap locals and window adds
  always_ff @(posedge clk) begin
    if (reset) begin
      link_wr_en_reg <= 1'b0;
      link_wr_window_reg <= '0;
      link_wr_index_reg <= 5'h00;
      link_wr_data_reg <= 32'h0000_0000;
      trap_nxt_wr_en_reg <= 1'b0;
      trap_nxt_wr_data_reg <= 32'h0000_0000;
    end else begin
      link_wr_en_reg <= 1'b0;
      trap_nxt_wr_en_reg <= 1'b0;
      link_wr_window_reg <= current_window_pointer_reg;
      if (trap_taken) begin
        link_wr_en_reg <= 1'b1;
        link_wr_window_reg <= wp_dec;
        link_wr_index_reg <= `BTS_TRAP_PC_INDEX;
        link_wr_data_reg <= pc_reg;
        trap_nxt_wr_en_reg <= 1'b1;
        trap_nxt_wr_data_reg <= next_program_counter_reg;
      end else if (exec && instr_op == OP_CALL) begin
        link_wr_en_reg <= 1'b1;
        link_wr_index_reg <= `BTS_CALL_LINK_INDEX;
        link_wr_data_reg <= pc_reg;
      end else if (exec && instr_op == OP_JUMP_LINK) begin
        link_wr_en_reg <= 1'b1;
        link_wr_index_reg <= dest_index;
        link_wr_data_reg <= pc_reg;
      end else if (save_ok || restore_ok) begin
        // sources read in the old window, result lands in the new one
        link_wr_en_reg <= 1'b1;
        link_wr_window_reg <= save_ok ? wp_dec : wp_inc;
        link_wr_index_reg <= dest_index;
        link_wr_data_reg <= reg_sum;
      end
    end
  end

  // one-cycle event pulses toward the trap logic
  always_ff @(posedge clk) begin
    if (reset) begin
      software_trap_reg <= 1'b0;
      illegal_instr_trap_reg <= 1'b0;
      reset_trap_reg <= 1'b0;
      window_overflow_reg <= 1'b0;
      window_underflow_reg <= 1'b0;
    end else begin
      software_trap_reg <= trap_taken;
      illegal_instr_trap_reg <= ret_illegal;
      reset_trap_reg <= ret_fault;
      window_overflow_reg <= save_ovf;
      window_underflow_reg <= restore_unf;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_pc_from_next: assert property (go && !trap_taken && !ret_illegal && !ret_fault
    |=> pc_reg == $past(next_program_counter_reg)) else $error("pc did not take next");
  a_seq_step_four: assert property (go && (annul_reg || instr_op == OP_OTHER)
    |=> next_program_counter_reg == $past(next_program_counter_reg) + 32'h4)
    else $error("next did not step by four");
  a_trap_entry_now: assert property (trap_taken |=> pc_reg[11:0] == 12'h000
    && !trap_enable_bit_reg && supervisor_reg && software_trap_reg
    && next_program_counter_reg == pc_reg + 32'h4) else $error("trap entry wrong");
  a_trap_type_code: assert property (trap_taken |=> trap_base_reg[11:4] ==
    8'h80 + {1'b0, $past(reg_sum[6:0])}) else $error("trap type wrong");
  a_false_trap_nop: assert property (exec && instr_op == OP_COND_TRAP && !int_true
    |=> $stable(trap_base_reg) && $stable(current_window_pointer_reg) && !software_trap_reg)
    else $error("untaken trap changed state");
  a_annul_untaken: assert property (exec && is_branch && !branch_true && annul_bit
    |=> annul_reg) else $error("untaken annul missed");
  a_taken_ignores_annul: assert property (exec && is_branch && branch_true && !always_form
    |=> !annul_reg) else $error("taken branch annulled");
  a_annul_quiet: assert property (go && annul_reg |=> $stable(current_window_pointer_reg)
    && !link_wr_en_reg && !software_trap_reg && !annul_reg) else $error("annulled slot acted");
  a_ret_illegal: assert property (ret_illegal |=> illegal_instr_trap_reg
    && $stable(current_window_pointer_reg)) else $error("return illegal missed");
  a_ret_fault_hold: assert property (ret_fault |=> error_mode_reg && reset_trap_reg
    ##1 error_mode_reg && !reset_trap_reg) else $error("return fault missed");
  a_save_wrap: assert property (save_ok |=> current_window_pointer_reg ==
    ($past(current_window_pointer_reg) == '0 ? CW'(NWIN - 1) : $past(wp_dec)))
    else $error("save window wrong");
  a_window_overflow: assert property (save_ovf |=> window_overflow_reg
    && $stable(current_window_pointer_reg)) else $error("overflow missed");
  a_call_link: assert property (exec && instr_op == OP_CALL |=> link_wr_en_reg
    && link_wr_index_reg == 5'h0F && link_wr_data_reg == $past(pc_reg))
    else $error("call link wrong");

  c_trap_taken: cover property (trap_taken ##1 go);
  c_annulled_slot: cover property (go && annul_reg);
  c_clean_return: cover property (ret_ok);
  c_save_restore: cover property (save_ok ##[1:4] restore_ok);
endmodule

// File: src/bts_window_unit.sv
// window pointer stepping with wrap and invalid-mask check
`timescale 1ns/1ps
module bts_window_unit #(
  parameter int NWIN = 8,
  parameter int CW = $clog2(NWIN)
) (
  input wire logic [CW-1:0] wp,
  input wire logic [NWIN-1:0] invalid_mask,
  output logic [CW-1:0] wp_inc,
  output logic [CW-1:0] wp_dec,
  output logic inc_invalid,
  output logic dec_invalid
);
  localparam logic [CW-1:0] LAST = CW'(NWIN - 1);

  // wrap by compare so a window count that is not a power of two still works
  always_comb begin
    wp_inc = (wp == LAST) ? '0 : wp + CW'(1);
    wp_dec = (wp == '0) ? LAST : wp - CW'(1);
    inc_invalid = invalid_mask[wp_inc];
    dec_invalid = invalid_mask[wp_dec];
  end
endmodule
